// ---- rfph_pkg.sv ----
// Shared constants and types for the radio buffer and packet handler
package rfph_pkg;
	localparam logic [6:0]  A_STATUS = 7'h03;
	localparam logic [6:0]  A_IRQEN  = 7'h05;
	localparam logic [6:0]  A_MODE   = 7'h07;
	localparam logic [6:0]  A_FUNC   = 7'h08;
	localparam logic [6:0]  A_DACC   = 7'h30;
	localparam logic [6:0]  A_HDR2   = 7'h33;
	localparam logic [6:0]  A_PRE    = 7'h34;
	localparam logic [6:0]  A_SYNC1  = 7'h36;
	localparam logic [6:0]  A_SYNC0  = 7'h37;
	localparam logic [6:0]  A_TXHD   = 7'h3D;
	localparam logic [6:0]  A_PKLEN  = 7'h3E;
	localparam logic [6:0]  A_CHHD   = 7'h42;
	localparam logic [6:0]  A_RXLEN  = 7'h4B;
	localparam logic [6:0]  A_MODCTL = 7'h70;
	localparam logic [6:0]  A_TXAF   = 7'h7C;
	localparam logic [6:0]  A_TXAE   = 7'h7D;
	localparam logic [6:0]  A_RXAF   = 7'h7E;
	localparam logic [6:0]  A_FIFO   = 7'h7F;
	localparam logic [7:0]  R_DACC   = 8'h8D;
	localparam logic [7:0]  R_HDR2   = 8'h22;
	localparam logic [7:0]  R_PRE    = 8'h08;
	localparam logic [7:0]  R_SYNC1  = 8'h2D;
	localparam logic [7:0]  R_SYNC0  = 8'hD4;
	localparam logic [5:0]  R_TXAF   = 6'h37;
	localparam logic [5:0]  R_TXAE   = 6'h04;
	localparam logic [5:0]  R_RXAF   = 6'h37;
	localparam int          B_XTON   = 0;
	localparam int          B_PLLON  = 1;
	localparam int          B_RXON   = 2;
	localparam int          B_TXON   = 3;
	localparam int          B_CLRTX  = 0;
	localparam int          B_CLRRX  = 1;
	localparam int          B_PKRX   = 7;
	localparam int          B_CRCD   = 5;
	localparam int          B_PKTX   = 3;
	localparam int          B_CRCEN  = 2;
	localparam int          B_FIXLEN = 3;
	localparam int          B_WHITE  = 0;
	localparam int          S_TXAF   = 6;
	localparam int          S_TXAE   = 5;
	localparam int          S_RXAF   = 4;
	localparam int          S_PKSENT = 2;
	localparam int          S_PKVAL  = 1;
	localparam int          S_CRCERR = 0;
	localparam int          BUF_DEPTH = 64;
	localparam int          BIT_DIV_DEF = 64;
	localparam logic [3:0]  PRE_MIN  = 4'h8;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [8:0]  PN9_SEED = 9'h1FF;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000, TX_PRE = 3'b001, TX_SYNC = 3'b010, TX_HDR = 3'b011,
		TX_LEN = 3'b100, TX_DATA = 3'b101, TX_CRC = 3'b110
	} rfph_tx_e;
	typedef enum logic [2:0] {
		RX_HUNT = 3'b000, RX_HDR = 3'b001, RX_LEN = 3'b010, RX_DATA = 3'b011, RX_CRC = 3'b100
	} rfph_rx_e;
endpackage

// ---- rfph_fifo_if.sv ----
// Byte buffer handshake bundle
`timescale 1ns/1ps
`default_nettype none
interface rfph_fifo_if #(parameter int W = 8, parameter int LW = 7);
	logic [W-1:0]  wdata;
	logic          wvalid;
	logic          wready;
	logic [W-1:0]  rdata;
	logic          rvalid;
	logic          rready;
	logic          clear;
	logic [LW-1:0] level;
	modport fifo (input wdata, wvalid, rready, clear, output wready, rdata, rvalid, level);
	modport user (output wdata, wvalid, rready, clear, input wready, rdata, rvalid, level);
endinterface
`default_nettype wire

// ---- rfph_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides and a fill level
`timescale 1ns/1ps
`default_nettype none
module rfph_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 64
) (
	input wire logic clock,
	input wire logic rst_n,
	rfph_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	wire wr = f.wvalid & f.wready;
	wire rd = f.rvalid & f.rready;
	assign f.wready = cnt != (AW+1)'(DEPTH);
	assign f.rvalid = cnt != '0;
	assign f.rdata  = mem[rp];
	assign f.level  = cnt;
	always_ff @(posedge clock) begin
		if (wr)
			mem[wp] <= f.wdata;
	end
	// Clear beats a simultaneous push or pop
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else if (f.clear) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			wp  <= wp + AW'(wr);
			rp  <= rp + AW'(rd);
			cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule // rfph_fifo
`default_nettype wire

// ---- rfph_top.sv ----
// Radio data buffers, thresholds and packet handler behind the serial register port
//
// How it works
// - Two separate 64-byte buffers: one for transmit, one for receive.
// - Burst writes to the buffer port push bytes into the transmit buffer.
// - Burst reads from the buffer port pop receive bytes onto serial out.
// - Transmit fill passing the almost-full level raises an event.
// - Transmit fill dropping below almost-empty level while sending raises an event.
// - Transmit stops by itself after packet sent or when no data remains.
// - Automatic exit clears transmit-on; other mode bits stay.
// - With synthesizer-on also set, the device returns to tune.
// - With oscillator-on also set, it returns to ready, oscillator kept.
// - Receive fill passing almost-full level raises an event.
// - Separate clear bits empty the receive and transmit buffers.
// - Disabled events keep the interrupt pin idle but still set status.
// - Packet handling enabled separately for transmit and receive.
// - Preamble, sync, header, length and CRC added around payload.
// - Preamble alternates ones and zeros, starting with zero.
// - Fixed length sends at most that many bytes, then CRC if enabled, then idles, flags sent.
// - Raw receive still needs preamble and sync, then stores every bit.
// - Raw receive does no whitening, CRC or header check.
// - Packet receive takes fixed or variable length, header optional.
// - Transmitted header and length come from registers.
// - CRC covers payload alone or also length and header.
// - Whitening XORs payload with PN9 restarted per payload.
`timescale 1ns/1ps
`default_nettype none
module rfph_top #(
	parameter int BIT_DIV = rfph_pkg::BIT_DIV_DEF
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic spi_sclk,
	input  wire logic spi_nsel,
	input  wire logic spi_sdi,
	output logic      spi_sdo,
	output logic      spi_sdo_oe,
	input  wire logic rx_bit_in,
	output logic      tx_bit_out,
	output logic      tx_active,
	output logic      interrupt_pin_n
);
	import rfph_pkg::*;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
	endfunction
	function automatic logic [8:0] pn_step(input logic [8:0] p);
		return {p[0] ^ p[5], p[8:1]};
	endfunction

	rfph_fifo_if txf ();
	rfph_fifo_if rxf ();
	rfph_fifo #(.DEPTH(BUF_DEPTH)) u_txbuf (.clock(clock), .rst_n(rst_n), .f(txf));
	rfph_fifo #(.DEPTH(BUF_DEPTH)) u_rxbuf (.clock(clock), .rst_n(rst_n), .f(rxf));

	logic [2:0] sck_s;
	logic [1:0] nsel_s;
	logic [1:0] sdi_s;
	logic [1:0] rxd_s;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sck_s  <= 3'h0;
			nsel_s <= 2'h3;
			sdi_s  <= 2'h0;
			rxd_s  <= 2'h0;
		end else begin
			sck_s  <= {sck_s[1:0], spi_sclk};
			nsel_s <= {nsel_s[0], spi_nsel};
			sdi_s  <= {sdi_s[0], spi_sdi};
			rxd_s  <= {rxd_s[0], rx_bit_in};
		end
	end
	wire sck_rise = sck_s[1] & ~sck_s[2];
	wire sck_fall = ~sck_s[1] & sck_s[2];
	wire sel      = ~nsel_s[1];

	// Serial port: command byte (R/W, address) then data bytes, MSB first
	logic [2:0] bcnt;
	logic       cmd_done;
	logic       is_wr;
	logic       wr_stb;
	logic       rd_stb;
	logic [6:0] addr;
	logic [6:0] wr_addr;
	logic [7:0] sh;
	logic [7:0] so;
	logic [7:0] wr_data;
	logic [7:0] rd_val;
	wire [7:0] sh_in    = {sh[6:0], sdi_s[1]};
	wire       byte_end = sel & sck_rise & (bcnt == 3'h7);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bcnt     <= 3'h0;
			cmd_done <= 1'b0;
			is_wr    <= 1'b0;
			wr_stb   <= 1'b0;
			rd_stb   <= 1'b0;
			addr     <= 7'h00;
			wr_addr  <= 7'h00;
			sh       <= 8'h00;
			wr_data  <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			if (!sel) begin
				bcnt     <= 3'h0;
				cmd_done <= 1'b0;
			end else if (sck_rise) begin
				sh   <= sh_in;
				bcnt <= bcnt + 3'h1;
				if (bcnt == 3'h7 && !cmd_done) begin
					cmd_done <= 1'b1;
					is_wr    <= sh[6];
					addr     <= sh_in[6:0];
					rd_stb   <= ~sh[6];
				end else if (bcnt == 3'h7) begin
					wr_stb  <= is_wr;
					wr_addr <= addr;
					wr_data <= sh_in;
					rd_stb  <= ~is_wr;
					// Buffer port does not auto-increment, so bursts stream
					if (addr != A_FIFO)
						addr <= addr + 7'h01;
				end
			end
		end
	end
	// Pop only after a byte has fully left, so an aborted burst loses nothing
	assign rxf.rready = byte_end & cmd_done & ~is_wr & (addr == A_FIFO);
	assign txf.wvalid = wr_stb & (wr_addr == A_FIFO);
	assign txf.wdata  = wr_data;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			so         <= 8'h00;
			spi_sdo    <= 1'b0;
			spi_sdo_oe <= 1'b0;
		end else begin
			spi_sdo_oe <= sel;
			if (rd_stb) begin
				so <= rd_val;
			end else if (sel && sck_fall) begin
				spi_sdo <= so[7];
				so      <= {so[6:0], 1'b0};
			end
		end
	end

	logic [7:0] irq_en, mode, func, dacc, hdr2, pre, sync1, sync0;
	logic [7:0] txhd, pklen, chhd, modctl, rlen, status;
	logic [5:0] txaf, txae, rxaf;
	logic       clr_tx, clr_rx, tx_done;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_en <= 8'h00;
			func   <= 8'h00;
			dacc   <= R_DACC;
			hdr2   <= R_HDR2;
			pre    <= R_PRE;
			sync1  <= R_SYNC1;
			sync0  <= R_SYNC0;
			txhd   <= 8'h00;
			pklen  <= 8'h00;
			chhd   <= 8'h00;
			modctl <= 8'h00;
			txaf   <= R_TXAF;
			txae   <= R_TXAE;
			rxaf   <= R_RXAF;
		end else if (wr_stb) begin
			case (wr_addr)
				A_IRQEN:  irq_en <= wr_data;
				A_FUNC:   func   <= {wr_data[7:2], 2'b00};
				A_DACC:   dacc   <= wr_data;
				A_HDR2:   hdr2   <= wr_data;
				A_PRE:    pre    <= wr_data;
				A_SYNC1:  sync1  <= wr_data;
				A_SYNC0:  sync0  <= wr_data;
				A_TXHD:   txhd   <= wr_data;
				A_PKLEN:  pklen  <= wr_data;
				A_CHHD:   chhd   <= wr_data;
				A_MODCTL: modctl <= wr_data;
				A_TXAF:   txaf   <= wr_data[5:0];
				A_TXAE:   txae   <= wr_data[5:0];
				A_RXAF:   rxaf   <= wr_data[5:0];
				default:  ;
			endcase
		end
	end

	// Clear bits act once per write and read back as zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clr_tx <= 1'b0;
			clr_rx <= 1'b0;
		end else begin
			clr_tx <= wr_stb & (wr_addr == A_FUNC) & wr_data[B_CLRTX];
			clr_rx <= wr_stb & (wr_addr == A_FUNC) & wr_data[B_CLRRX];
		end
	end
	assign txf.clear = clr_tx;
	assign rxf.clear = clr_rx;

	// Only transmit-on drops at the end; oscillator and synthesizer bits pick the landing mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			mode <= 8'h00;
		else if (wr_stb && wr_addr == A_MODE)
			mode <= wr_data;
		else if (tx_done)
			mode[B_TXON] <= 1'b0;
	end

	always_comb begin
		unique case (addr)
			A_STATUS: rd_val = status;
			A_IRQEN:  rd_val = irq_en;
			A_MODE:   rd_val = mode;
			A_FUNC:   rd_val = func;
			A_DACC:   rd_val = dacc;
			A_HDR2:   rd_val = hdr2;
			A_PRE:    rd_val = pre;
			A_SYNC1:  rd_val = sync1;
			A_SYNC0:  rd_val = sync0;
			A_TXHD:   rd_val = txhd;
			A_PKLEN:  rd_val = pklen;
			A_CHHD:   rd_val = chhd;
			A_RXLEN:  rd_val = rlen;
			A_MODCTL: rd_val = modctl;
			A_TXAF:   rd_val = {2'b00, txaf};
			A_TXAE:   rd_val = {2'b00, txae};
			A_RXAF:   rd_val = {2'b00, rxaf};
			A_FIFO:   rd_val = rxf.rdata;
			default:  rd_val = 8'h00;
		endcase
	end

	logic [15:0] div;
	wire bit_en = div == 16'(BIT_DIV - 1);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			div <= 16'h0000;
		else
			div <= bit_en ? 16'h0000 : div + 16'h0001;
	end

	// Transmit framer
	rfph_tx_e    st, nx_st;
	logic [7:0]  sh_t, nx_sh, dcnt;
	logic [2:0]  bc;
	logic [10:0] cnt;
	logic [15:0] crc;
	logic [8:0]  pn;
	logic        pop, done;
	wire pkt_tx  = dacc[B_PKTX];
	wire hdr_on  = hdr2[6:4] != 3'b000;
	wire fix     = hdr2[B_FIXLEN];
	wire white   = modctl[B_WHITE];
	wire tbit    = (st == TX_PRE) ? cnt[0] : sh_t[7] ^ (st == TX_DATA & pkt_tx & white & pn[0]);
	wire crc_on  = pkt_tx & dacc[B_CRCEN] &
		(st == TX_DATA | ((st == TX_HDR | st == TX_LEN) & ~dacc[B_CRCD]));
	wire [15:0] crc_nx = crc_step(crc, sh_t[7]);
	wire more    = txf.rvalid & (~pkt_tx | dcnt < pklen);
	always_comb begin
		nx_st = st;
		nx_sh = 8'h00;
		pop   = 1'b0;
		done  = 1'b0;
		unique case (st)
			TX_IDLE, TX_PRE: nx_st = st;
			TX_SYNC: begin
				if (!cnt[0])
					nx_sh = sync0;
				else if (pkt_tx && hdr_on) begin
					nx_st = TX_HDR;
					nx_sh = txhd;
				end else if (pkt_tx && !fix) begin
					nx_st = TX_LEN;
					nx_sh = pklen;
				end else
					nx_st = TX_DATA;
			end
			TX_HDR: begin
				nx_st = fix ? TX_DATA : TX_LEN;
				nx_sh = pklen;
			end
			TX_LEN, TX_DATA: nx_st = TX_DATA;
			TX_CRC: begin
				nx_sh = crc[7:0];
				done  = cnt[0];
			end
			default: nx_st = TX_IDLE;
		endcase
		if (nx_st == TX_DATA) begin
			if (more) begin
				nx_sh = txf.rdata;
				pop   = 1'b1;
			end else if (pkt_tx && dacc[B_CRCEN]) begin
				nx_st = TX_CRC;
				nx_sh = crc_nx[15:8];
			end else
				done = 1'b1;
		end
		if (done)
			nx_st = TX_IDLE;
	end
	wire byte_t = bit_en & (st != TX_IDLE) & (st != TX_PRE) & (bc == 3'h7);
	assign txf.rready = byte_t & pop;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st         <= TX_IDLE;
			sh_t       <= 8'h00;
			bc         <= 3'h0;
			cnt        <= 11'h000;
			dcnt       <= 8'h00;
			crc        <= CRC_INIT;
			pn         <= PN9_SEED;
			tx_bit_out <= 1'b0;
			tx_done    <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (st == TX_IDLE) begin
				if (mode[B_TXON] && !tx_done) begin
					st   <= TX_PRE;
					cnt  <= 11'h000;
					bc   <= 3'h0;
					dcnt <= 8'h00;
					crc  <= CRC_INIT;
					pn   <= PN9_SEED;
				end
			end else if (bit_en) begin
				tx_bit_out <= tbit;
				if (st == TX_PRE) begin
					// Preamble length counts nibbles
					if (cnt == {1'b0, pre, 2'b00} - 11'h001) begin
						st   <= TX_SYNC;
						sh_t <= sync1;
						cnt  <= 11'h000;
					end else
						cnt <= cnt + 11'h001;
				end else begin
					if (crc_on)
						crc <= crc_nx;
					if (st == TX_DATA)
						pn <= pn_step(pn);
					if (bc == 3'h7) begin
						st      <= nx_st;
						sh_t    <= nx_sh;
						cnt     <= (nx_st == st) ? cnt + 11'h001 : 11'h000;
						dcnt    <= dcnt + {7'h00, pop};
						tx_done <= done;
					end else
						sh_t <= {sh_t[6:0], 1'b0};
					bc <= bc + 3'h1;
				end
			end
		end
	end

	// Receive path
	rfph_rx_e    rs;
	logic [15:0] rsr, rcrc;
	logic [7:0]  rsh, rcnt;
	logic [2:0]  rbc;
	logic [3:0]  pre_cnt;
	logic [8:0]  rpn;
	logic        pre_seen, hdr_ok;
	wire pkt_rx  = dacc[B_PKRX];
	wire rbit    = rxd_s[1];
	wire rb      = rbit ^ (rs == RX_DATA & pkt_rx & white & rpn[0]);
	wire [7:0] rbyte = {rsh[6:0], rb};
	wire rcrc_on = pkt_rx & dacc[B_CRCEN] & (rs == RX_DATA | rs == RX_CRC |
		((rs == RX_HDR | rs == RX_LEN) & ~dacc[B_CRCD]));
	wire [15:0] rcrc_nx = crc_step(rcrc, rb);
	wire rx_last = (rcnt + 8'h01) == rlen;
	wire rx_step = bit_en & mode[B_RXON] & (rs != RX_HUNT) & (rbc == 3'h7);
	wire rx_end  = rx_step & ((rs == RX_DATA & pkt_rx & rx_last & ~dacc[B_CRCEN]) | (rs == RX_CRC & rcnt[0]));
	wire crc_ok  = (rs != RX_CRC) | (rcrc_nx == 16'h0000);
	assign rxf.wvalid = rx_step & (rs == RX_DATA);
	assign rxf.wdata  = rbyte;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rs <= RX_HUNT;
			rsr <= 16'h0000;
			rsh <= 8'h00;
			rcnt <= 8'h00;
			rbc <= 3'h0;
			rlen <= 8'h00;
			pre_cnt <= 4'h0;
			pre_seen <= 1'b0;
			hdr_ok <= 1'b0;
			rcrc <= CRC_INIT;
			rpn <= PN9_SEED;
		end else if (!mode[B_RXON]) begin
			rs <= RX_HUNT;
			pre_cnt <= 4'h0;
			pre_seen <= 1'b0;
		end else if (bit_en) begin
			rsr <= {rsr[14:0], rbit};
			if (rs == RX_HUNT) begin
				pre_cnt  <= (rbit == rsr[0]) ? 4'h0 : (pre_cnt == PRE_MIN) ? pre_cnt : pre_cnt + 4'h1;
				pre_seen <= pre_seen | (pre_cnt == PRE_MIN);
				if (pre_seen && {rsr[14:0], rbit} == {sync1, sync0}) begin
					rs <= !pkt_rx ? RX_DATA : hdr_on ? RX_HDR : fix ? RX_DATA : RX_LEN;
					rbc <= 3'h0;
					rcnt <= 8'h00;
					rlen <= pklen;
					hdr_ok <= 1'b1;
					pre_seen <= 1'b0;
					rcrc <= CRC_INIT;
					rpn <= PN9_SEED;
				end
			end else begin
				rsh <= rbyte;
				rbc <= rbc + 3'h1;
				if (rcrc_on)
					rcrc <= rcrc_nx;
				if (rs == RX_DATA)
					rpn <= pn_step(rpn);
				if (rbc == 3'h7) begin
					unique case (rs)
						RX_HDR: begin
							hdr_ok <= rbyte == chhd;
							rs <= fix ? RX_DATA : RX_LEN;
						end
						RX_LEN: begin
							rlen <= rbyte;
							rs <= RX_DATA;
						end
						RX_DATA: begin
							rcnt <= rx_last ? 8'h00 : rcnt + 8'h01;
							if (pkt_rx && rx_last)
								rs <= dacc[B_CRCEN] ? RX_CRC : RX_HUNT;
						end
						RX_CRC: begin
							rcnt <= rcnt + 8'h01;
							if (rcnt[0])
								rs <= RX_HUNT;
						end
						default: rs <= RX_HUNT;
					endcase
				end
			end
		end
	end

	// Threshold events and sticky status
	logic [2:0] hit_q;
	logic [7:0] ev;
	wire txaf_hit = txf.level > {1'b0, txaf};
	wire txae_hit = (txf.level < {1'b0, txae}) & (st != TX_IDLE);
	wire rxaf_hit = rxf.level > {1'b0, rxaf};
	always_comb begin
		ev           = 8'h00;
		ev[S_TXAF]   = txaf_hit & ~hit_q[0];
		ev[S_TXAE]   = txae_hit & ~hit_q[1];
		ev[S_RXAF]   = rxaf_hit & ~hit_q[2];
		ev[S_PKSENT] = tx_done;
		ev[S_PKVAL]  = rx_end & hdr_ok & crc_ok;
		ev[S_CRCERR] = rx_end & ~crc_ok;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hit_q  <= 3'h0;
			status <= 8'h00;
		end else begin
			hit_q  <= {rxaf_hit, txae_hit, txaf_hit};
			// A new event in the read cycle survives the clear
			status <= (status & ~{8{rd_stb & (addr == A_STATUS)}}) | ev;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_pin_n <= 1'b1;
			tx_active       <= 1'b0;
		end else begin
			interrupt_pin_n <= ~|(status & irq_en);
			tx_active       <= st != TX_IDLE;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_set_wins; ev[S_PKSENT] |=> status[S_PKSENT]; endproperty
	a_set_wins: assert property (p_set_wins) else $error("status event lost");
	property p_irq_on; (|(status & irq_en)) |=> !interrupt_pin_n; endproperty
	a_irq_on: assert property (p_irq_on) else $error("enabled event not on pin");
	property p_irq_mask; ((status & irq_en) == 8'h00) |=> interrupt_pin_n; endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked event drove pin");
	property p_txon_clr;
		(tx_done && !wr_stb) |=> !mode[B_TXON] && mode[B_PLLON] == $past(mode[B_PLLON]) && mode[B_XTON] == $past(mode[B_XTON]);
	endproperty
	a_txon_clr: assert property (p_txon_clr) else $error("bad mode after auto exit");
	property p_pre0; (bit_en && st == TX_PRE && cnt == 11'h000) |=> !tx_bit_out; endproperty
	a_pre0: assert property (p_pre0) else $error("preamble not starting with zero");
	property p_clr; clr_tx |=> txf.level == 7'h00; endproperty
	a_clr: assert property (p_clr) else $error("transmit buffer not cleared");
	property p_txaf; (txaf_hit && !hit_q[0]) |=> status[S_TXAF] ##1 hit_q[0] || !txaf_hit; endproperty
	a_txaf: assert property (p_txaf) else $error("almost full event missed");
	property p_len; (tx_done && pkt_tx) |-> dcnt <= pklen; endproperty
	a_len: assert property (p_len) else $error("sent too many bytes");
	property p_rxaf; $rose(rxaf_hit) |=> status[S_RXAF]; endproperty
	a_rxaf: assert property (p_rxaf) else $error("rx almost full event missed");
endmodule // rfph_top
`default_nettype wire

// ---- rfph_host.sv ----
// Host controller model driving the serial register port
`timescale 1ns/1ps
`default_nettype none
module rfph_host (
	input  wire logic clock,
	output logic      spi_sclk,
	output logic      spi_nsel,
	output logic      spi_sdi,
	input  wire logic spi_sdo
);
	initial begin
		spi_sclk = 1'b0;
		spi_nsel = 1'b1;
		spi_sdi  = 1'b0;
	end
	// Above the sync and decode delay of the port
	task automatic half();
		repeat (5) @(negedge clock);
	endtask
	// Mode 0, MSB first, read bit taken at the rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spi_sdi = tx[i];
			half();
			spi_sclk = 1'b1;
			rx[i] = spi_sdo;
			half();
			spi_sclk = 1'b0;
		end
	endtask
	task automatic sel(input logic on);
		half();
		spi_nsel = !on;
		// Released data line must not keep its last value
		if (!on)
			spi_sdi = !spi_sdi;
		half();
	endtask
endmodule // rfph_host
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the radio buffer and packet handler
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rfph_pkg::*;
	logic clock, rst_n, spi_sclk, spi_nsel, spi_sdi, spi_sdo, spi_sdo_oe;
	logic rx_bit_in, tx_bit_out, tx_active, interrupt_pin_n;
	logic [7:0] pre        = 8'h00;
	int         k          = 0;
	int         n_mismatch = 0;
	int         n_tests    = 0;
	int         cyc        = 0;
	rfph_top #(.BIT_DIV(4)) dut (.clock(clock), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_nsel(spi_nsel),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .rx_bit_in(rx_bit_in),
		.tx_bit_out(tx_bit_out), .tx_active(tx_active), .interrupt_pin_n(interrupt_pin_n));
	rfph_host host (.clock(clock), .spi_sclk(spi_sclk), .spi_nsel(spi_nsel), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic end_sim();
		$display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// First eight bits, each taken late in its period so any bit-clock phase works
	always @(negedge clock) begin
		if (tx_active) begin
			if (k[1:0] == 2'd3 && k < 32)
				pre = {pre[6:0], tx_bit_out};
			k++;
		end else
			k = 0;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		host.sel(1'b1);
		host.xfer({1'b1, a}, x);
		host.xfer(d, x);
		host.sel(1'b0);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] x, d;
		host.sel(1'b1);
		check({7'h00, spi_sdo_oe}, 8'h01);
		host.xfer({1'b0, a}, x);
		host.xfer(8'h00, d);
		host.sel(1'b0);
		check({7'h00, spi_sdo_oe}, 8'h00);
		check(d & m, e);
	endtask
	task automatic push3();
		logic [7:0] x;
		host.sel(1'b1);
		host.xfer(8'hFF, x);
		for (int i = 1; i <= 3; i++)
			host.xfer(8'(i * 17), x);
		host.sel(1'b0);
	endtask
	task automatic t_regs();
		rdc(A_TXAF, 8'hFF, 8'h37);
		rdc(A_TXAE, 8'hFF, 8'h04);
		rdc(A_RXAF, 8'hFF, 8'h37);
		rdc(A_FUNC, 8'hFF, 8'h00);
		rdc(7'h10, 8'hFF, 8'h00);
		wr(A_TXAF, 8'hFF);
		rdc(A_TXAF, 8'hFF, 8'h3F);
	endtask
	task automatic t_txfull();
		wr(A_TXAF, 8'h02);
		wr(A_IRQEN, 8'h40);
		push3();
		check({7'h00, interrupt_pin_n}, 8'h00);
		rdc(A_STATUS, 8'h40, 8'h40);
		check({7'h00, interrupt_pin_n}, 8'h01);
		wr(A_FUNC, 8'h01);
		rdc(A_FUNC, 8'hFF, 8'h00);
		// Crossing again only if the clear really emptied it
		push3();
		rdc(A_STATUS, 8'h40, 8'h40);
	endtask
	task automatic t_tx(input logic [7:0] mode, input logic [7:0] left);
		wr(A_IRQEN, 8'h00);
		wr(A_TXAE, 8'h02);
		wr(A_PKLEN, 8'h02);
		// Start from the same fill as the first run so almost-empty is crossed
		if (mode == 8'h0A) begin
			wr(A_FUNC, 8'h01);
			push3();
		end
		wr(A_MODE, mode);
		for (int i = 0; i < 3000 && tx_active !== 1'b0; i++)
			@(negedge clock);
		check(pre, 8'h55);
		check({7'h00, interrupt_pin_n}, 8'h01);
		rdc(A_MODE, 8'hFF, left);
		rdc(A_STATUS, 8'h24, 8'h24);
		wr(A_MODE, 8'h00);
		rdc(A_MODE, 8'hFF, 8'h00);
	endtask
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			rx_bit_in = b[i];
			repeat (4) @(negedge clock);
		end
	endtask
	task automatic t_rx();
		logic [7:0] x, d;
		wr(A_DACC, 8'h0D);
		wr(A_RXAF, 8'h01);
		wr(A_IRQEN, 8'h10);
		wr(A_MODE, 8'h05);
		send(8'h55);
		send(8'h55);
		send(R_SYNC1);
		send(R_SYNC0);
		send(8'h5A);
		send(8'hC3);
		repeat (20) @(negedge clock);
		check({7'h00, interrupt_pin_n}, 8'h00);
		wr(A_MODE, 8'h01);
		host.sel(1'b1);
		host.xfer({1'b0, A_FIFO}, x);
		host.xfer(8'h00, d);
		check(d, 8'h5A);
		host.xfer(8'h00, d);
		check(d, 8'hC3);
		host.sel(1'b0);
	endtask
	// Packet receive: header byte, length byte, two payload bytes, no CRC
	task automatic t_pkrx();
		wr(A_FUNC, 8'h02);
		wr(A_DACC, 8'h80);
		wr(A_HDR2, 8'h20);
		wr(A_MODE, 8'h05);
		send(8'h55);
		send(8'h55);
		send(R_SYNC1);
		send(R_SYNC0);
		send(8'h00);
		send(8'h02);
		send(8'h3C);
		send(8'hA5);
		wr(A_MODE, 8'h01);
		rdc(A_RXLEN, 8'hFF, 8'h02);
		rdc(A_STATUS, 8'h03, 8'h02);
		rdc(A_FIFO, 8'hFF, 8'h3C);
	endtask
	initial begin
		rst_n = 1'b0;
		rx_bit_in = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		repeat (3) @(negedge clock);
		t_regs();
		t_txfull();
		t_tx(8'h09, 8'h01);
		t_tx(8'h0A, 8'h02);
		t_rx();
		t_pkrx();
		end_sim();
	end
endmodule // tb
`default_nettype wire
